// >>> hdl/sadc_regs.vh
/*
 * Register offsets, field positions, reset values and request source
 * numbers of the short-address DMA channel.
 * Assumes a word-wide plain register port; each register at one index.
 */
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// Register offsets
`define SADC_OFF_MEM_ADDR    4'h0
`define SADC_OFF_IO_ADDR     4'h1
`define SADC_OFF_XFER_COUNT  4'h2
`define SADC_OFF_CTRL        4'h3
`define SADC_OFF_BAND_CTRL   4'h4
`define SADC_OFF_STATUS      4'h5

// Control register fields
`define SADC_CTRL_DIR        0
`define SADC_CTRL_SIZE       1
`define SADC_CTRL_STEP       2
`define SADC_CTRL_END_IE     3
`define SADC_CTRL_RPT        4
`define SADC_CTRL_SRC_LSB    5
`define SADC_CTRL_SRC_MSB    8
`define SADC_CTRL_EN         9

// Band control register fields
`define SADC_BAND_SAE        0

// Reset values
`define SADC_RST_CTRL        10'h000
`define SADC_RST_ADDR        24'h000000
`define SADC_RST_COUNT       16'h0000

// Upper bits forced onto the I/O address
`define SADC_IO_HIGH         8'hFF

// Request source codes
`define SADC_SRC_ADC         4'h0
`define SADC_SRC_TX_EMPTY    4'h1
`define SADC_SRC_RX_FULL     4'h2
`define SADC_SRC_TIMER0      4'h3
`define SADC_SRC_TIMER5      4'h8
`define SADC_SRC_EXT         4'h9

`endif

// >>> hdl/sadc_channel.v
/*
 * One short-address DMA channel: idle, repeat and single-address modes.
 * Assumes a bus that ends each access with bus_done_i after any number
 * of wait cycles, and one-cycle request pulses from the request sources.
 */
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "sadc_regs.vh"

// Function
// R01: Repeat and end-irq both set selects idle
// R02: Idle mode keeps both addresses fixed
// R03: I/O address upper byte forced to ones
// R04: Direction bit swaps source and destination
// R05: Idle count decrements; zero clears enable
// R06: Count end raises irq when enabled
// R07: Starting count zero means 65536 transfers
// R08: Listed peripheral and external requests start transfers; the external request is gated to channel B only
// R09: Idle single-address only on channel B
// R10: Repeat set, end-irq clear selects repeat
// R11: Repeat steps address by one or two
// R12: Repeat count eight bits; zero means 256
// R13: Run byte reloads from hold byte
// R14: Reload restores memory address by round length
// R15: Software loads equal hold and run bytes
// R16: Repeat runs until disabled, never interrupts
// R17: Re-enable resumes after last transfer
// R18: Software enables single-address on channel B
// R19: Single-address uses ack strobe, direction sets role
// R20: Single-address accesses both sides in one cycle
// R21: Single-address follows the selected count mode
// R22: Size and step direction bit meanings
module sadc_channel #(
    parameter IS_CHAN_B = 1
) (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        nrst_i,
    // Register port
    input  wire [3:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    // Request sources
    input  wire        adc_end_i,
    input  wire        tx_empty_i,
    input  wire        rx_full_i,
    input  wire [5:0]  timer_cmp_a_i,
    input  wire        ext_req_i,
    // On-chip bus
    output wire        bus_req_o,
    input  wire        bus_done_i,
    output reg  [23:0] src_addr_o,
    output reg  [23:0] dst_addr_o,
    output reg         word_o,
    output reg         single_o,
    output reg         xfer_ack_strobe_n_o,
    output reg         xfer_ack_write_o,
    // Interrupt request
    output wire        end_irq_o
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_BUSY = 2'b10;

    reg [1:0]  state_q;
    reg [9:0]  ctrl_q;
    reg        sae_q;
    reg [23:0] mem_addr_q;
    reg [15:0] io_addr_q;
    reg [15:0] count_q;
    reg        end_flag_q;
    reg        pend_q;

    wire       dir     = ctrl_q[`SADC_CTRL_DIR];
    wire       size    = ctrl_q[`SADC_CTRL_SIZE];
    wire       step_dn = ctrl_q[`SADC_CTRL_STEP];
    wire       end_ie  = ctrl_q[`SADC_CTRL_END_IE];
    wire       rpt     = ctrl_q[`SADC_CTRL_RPT];
    wire [3:0] src_sel = ctrl_q[`SADC_CTRL_SRC_MSB:`SADC_CTRL_SRC_LSB];
    wire       enable  = ctrl_q[`SADC_CTRL_EN];

    wire mode_idle   = rpt & end_ie;                           // R01
    wire mode_repeat = rpt & ~end_ie;                          // R10
    // Single-address only takes effect on channel B
    wire single = sae_q & (IS_CHAN_B != 0);                    // R18 R09

    // Timer compare requests, one gate per timer channel
    wire [5:0] timer_hit;
    genvar t;
    generate
        for (t = 0; t < 6; t = t + 1) begin : g_timer
            assign timer_hit[t] = timer_cmp_a_i[t] &
                                  (src_sel == (`SADC_SRC_TIMER0 + t));
        end
    endgenerate

    // Request source selection
    reg req_sel;
    always @* begin                                            // R08
        req_sel = 1'b0;
        if (src_sel == `SADC_SRC_ADC) begin
            req_sel = adc_end_i;
        end else if (src_sel == `SADC_SRC_TX_EMPTY) begin
            req_sel = tx_empty_i;
        end else if (src_sel == `SADC_SRC_RX_FULL) begin
            req_sel = rx_full_i;
        end else if (src_sel >= `SADC_SRC_TIMER0 &&
                     src_sel <= `SADC_SRC_TIMER5) begin
            req_sel = |timer_hit;
        end else if (src_sel == `SADC_SRC_EXT) begin
            // External requests are wired to channel B only
            req_sel = ext_req_i & (IS_CHAN_B != 0);
        end
    end

    // Address step: 1 for bytes, 2 for words
    wire [23:0] step    = size ? 24'h000002 : 24'h000001;     // R22 R11
    wire [7:0]  hold    = count_q[15:8];
    wire [7:0]  run     = count_q[7:0];
    wire [7:0]  run_dec = run - 8'h01;
    // Zero hold counts as 256 transfers per round
    wire [8:0]  round   = (hold == 8'h00) ? 9'h100 : {1'b0, hold}; // R12
    wire [23:0] span    = size ? {14'h0000, round, 1'b0}
                               : {15'h0000, round};
    wire [23:0] io_full = {`SADC_IO_HIGH, io_addr_q};         // R03

    wire done = (state_q == ST_BUSY) & bus_done_i;
    wire wr_ctrl = reg_wr_i & (reg_addr_i == `SADC_OFF_CTRL);
    // A control write in the same cycle defers the start by one cycle
    wire go_busy = (state_q == ST_IDLE) & enable & pend_q & ~wr_ctrl;
    // Count end in idle mode, and in the plain count mode, single-address or dual
    wire count_end = done & ~mode_repeat & (count_q == 16'h0001);

    assign bus_req_o = (state_q == ST_BUSY);
    assign end_irq_o = end_flag_q;

    // Transfer state machine and address/count registers
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= ST_IDLE;
            ctrl_q     <= `SADC_RST_CTRL;
            sae_q      <= 1'b0;
            mem_addr_q <= `SADC_RST_ADDR;
            io_addr_q  <= `SADC_RST_COUNT;
            count_q    <= `SADC_RST_COUNT;
            end_flag_q <= 1'b0;
            pend_q     <= 1'b0;
        end else begin
            // Register writes
            if (reg_wr_i) begin
                if (reg_addr_i == `SADC_OFF_MEM_ADDR) begin
                    mem_addr_q <= reg_wdata_i[23:0];
                end else if (reg_addr_i == `SADC_OFF_IO_ADDR) begin
                    io_addr_q <= reg_wdata_i[15:0];
                end else if (reg_addr_i == `SADC_OFF_XFER_COUNT) begin
                    count_q <= reg_wdata_i[15:0];
                end else if (reg_addr_i == `SADC_OFF_CTRL) begin
                    ctrl_q <= reg_wdata_i[9:0];
                end else if (reg_addr_i == `SADC_OFF_BAND_CTRL) begin
                    sae_q <= reg_wdata_i[`SADC_BAND_SAE];
                end
            end
            // Request latch; one request yields one transfer
            if (enable & req_sel & (state_q == ST_IDLE)) begin
                pend_q <= 1'b1;
            end else if (!enable) begin
                pend_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    // Disabled channel keeps addresses and count for resume; a pending request is dropped
                    if (go_busy) begin                     // R17
                        state_q <= ST_BUSY;
                        pend_q  <= 1'b0;
                    end
                end
                ST_BUSY: begin
                    if (bus_done_i) begin
                        state_q <= ST_IDLE;
                        if (mode_repeat) begin
                            if (run_dec == 8'h00) begin    // R13
                                count_q[7:0] <= hold;
                                // Net of the last step and restore
                                if (step_dn) begin         // R14
                                    mem_addr_q <= mem_addr_q - step
                                                  + span;
                                end else begin
                                    mem_addr_q <= mem_addr_q + step
                                                  - span;
                                end
                            end else begin
                                count_q[7:0] <= run_dec;
                                if (step_dn) begin         // R11
                                    mem_addr_q <= mem_addr_q - step;
                                end else begin
                                    mem_addr_q <= mem_addr_q + step;
                                end
                            end
                        end else begin
                            // Wraps from zero, giving 65536
                            count_q <= count_q - 16'h0001; // R05 R07 R02
                            if (!mode_idle) begin          // R21
                                if (step_dn) begin
                                    mem_addr_q <= mem_addr_q - step;
                                end else begin
                                    mem_addr_q <= mem_addr_q + step;
                                end
                            end
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            // Count end clears enable; repeat never ends itself
            if (count_end) begin                           // R05 R16
                ctrl_q[`SADC_CTRL_EN] <= 1'b0;
            end
            // Sticky end flag; set wins over software clear
            if (count_end & end_ie) begin                  // R06
                end_flag_q <= 1'b1;
            end else if (reg_wr_i & (reg_addr_i == `SADC_OFF_STATUS)
                         & reg_wdata_i[0]) begin
                end_flag_q <= 1'b0;
            end
        end
    end

    // Bus address and strobe outputs
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_addr_o          <= `SADC_RST_ADDR;
            dst_addr_o          <= `SADC_RST_ADDR;
            word_o              <= 1'b0;
            single_o            <= 1'b0;
            xfer_ack_strobe_n_o <= 1'b1;
            xfer_ack_write_o    <= 1'b0;
        end else begin
            word_o   <= size;
            single_o <= single;                            // R20
            if (!dir) begin                                // R04
                src_addr_o <= mem_addr_q;
                dst_addr_o <= single ? mem_addr_q : io_full;
            end else begin
                src_addr_o <= single ? mem_addr_q : io_full;
                dst_addr_o <= mem_addr_q;
            end
            // Strobe asserted for the whole bus access
            // Held low through every wait state until the done edge
            xfer_ack_strobe_n_o <= ~(single & (go_busy |
                                     ((state_q == ST_BUSY) & ~bus_done_i))); // R19
            xfer_ack_write_o    <= ~dir;                   // R19
            if (done) begin
                xfer_ack_strobe_n_o <= 1'b1;
            end
        end
    end

    // Read data one cycle after the read strobe
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `SADC_OFF_MEM_ADDR) begin
                reg_rdata_o <= {8'h00, mem_addr_q};
            end else if (reg_addr_i == `SADC_OFF_IO_ADDR) begin
                reg_rdata_o <= {16'h0000, io_addr_q};
            end else if (reg_addr_i == `SADC_OFF_XFER_COUNT) begin
                reg_rdata_o <= {16'h0000, count_q};
            end else if (reg_addr_i == `SADC_OFF_CTRL) begin
                reg_rdata_o <= {22'h000000, ctrl_q};
            end else if (reg_addr_i == `SADC_OFF_BAND_CTRL) begin
                reg_rdata_o <= {31'h00000000, sae_q};
            end else if (reg_addr_i == `SADC_OFF_STATUS) begin
                reg_rdata_o <= {30'h00000000, bus_req_o, end_flag_q};
            end else begin
                reg_rdata_o <= 32'h00000000;
            end
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule

// >>> verification/sadc_channel_checker.sv
/* Port assertions of the short-address DMA channel.
   Assumes it is bound to sadc_channel and sees its ports only. */
`timescale 1ns/1ns
module sadc_channel_checker (
    input wire        mclk_i,
    input wire        nrst_i,
    input wire [3:0]  reg_addr_i,
    input wire        reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire        adc_end_i,
    input wire        tx_empty_i,
    input wire        rx_full_i,
    input wire [5:0]  timer_cmp_a_i,
    input wire        ext_req_i,
    input wire        bus_req_o,
    input wire        bus_done_i,
    input wire [23:0] src_addr_o,
    input wire [23:0] dst_addr_o,
    input wire        single_o,
    input wire        xfer_ack_strobe_n_o,
    input wire        end_irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    wire req_any = adc_end_i | tx_empty_i | rx_full_i | (|timer_cmp_a_i)
                   | ext_req_i;

    a_io_high_ones: assert property (bus_req_o && !single_o |->
        src_addr_o[23:16] == 8'hFF || dst_addr_o[23:16] == 8'hFF)
        else $error("io address upper byte not all ones");
    a_single_same: assert property (bus_req_o && single_o |->
        src_addr_o == dst_addr_o) else $error("single access split");
    a_strobe_single: assert property (bus_req_o && single_o |->
        !xfer_ack_strobe_n_o) else $error("strobe missing");
    a_strobe_dual: assert property (!single_o |->
        xfer_ack_strobe_n_o) else $error("strobe in dual access");
    a_req_hold: assert property (bus_req_o && !bus_done_i |=> bus_req_o)
        else $error("bus request dropped early");
    a_req_release: assert property (bus_req_o && bus_done_i |=> !bus_req_o)
        else $error("bus request held after done");
    a_irq_cause: assert property ($rose(end_irq_o) |->
        $past(bus_done_i) || $past(bus_done_i, 2))
        else $error("end irq without transfer");
    a_req_cause: assert property ($rose(bus_req_o) |->
        $past(req_any, 2)) else $error("transfer without request");
    a_rdata_quiet: assert property (!$past(reg_rd_i) |->
        reg_rdata_o == 32'h0) else $error("read data outside slot");
    a_rdata_unmap: assert property ($past(reg_rd_i) &&
        $past(reg_addr_i) > 4'h5 |-> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");

    c_single: cover property (bus_req_o && single_o);
    c_dual: cover property (bus_req_o && bus_done_i && !single_o);
    c_irq: cover property ($rose(end_irq_o));
endmodule

bind sadc_channel sadc_channel_checker chk_u (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .adc_end_i(adc_end_i),
    .tx_empty_i(tx_empty_i), .rx_full_i(rx_full_i),
    .timer_cmp_a_i(timer_cmp_a_i), .ext_req_i(ext_req_i),
    .bus_req_o(bus_req_o), .bus_done_i(bus_done_i),
    .src_addr_o(src_addr_o), .dst_addr_o(dst_addr_o), .single_o(single_o),
    .xfer_ack_strobe_n_o(xfer_ack_strobe_n_o), .end_irq_o(end_irq_o));

// >>> verification/sadc_bus_model.sv
/* On-chip bus partner: one done pulse per access after wait_i cycles.
   Assumes the channel holds its request until it sees done. */
`timescale 1ns/1ns
module sadc_bus_model (
    input  wire       mclk_i,
    input  wire       nrst_i,
    input  wire       bus_req_i,
    input  wire [3:0] wait_i,
    output reg        bus_done_o
);
    reg [3:0] cnt_q;
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q      <= 4'h0;
            bus_done_o <= 1'b0;
        end else if (bus_req_i && !bus_done_o && cnt_q == wait_i) begin
            cnt_q      <= 4'h0;
            bus_done_o <= 1'b1;
        end else begin
            bus_done_o <= 1'b0;
            if (bus_req_i && !bus_done_o)
                cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// >>> verification/sadc_channel_tb.sv
/* Self-checking bench of the DMA channel in idle, repeat and single mode.
   Assumes the bus model answers every access; clock 100 MHz. */
`timescale 1ns/1ns
`include "sadc_regs.vh"
module sadc_channel_tb;
    reg         mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, got;
    reg  [3:0]  addr = 4'h0, wt = 4'h0;
    reg  [31:0] wdata = 32'h0, d;
    reg  [9:0]  reqs = 10'h000;
    reg  [23:0] sa, da;
    reg         sn, sw, sl;
    wire [31:0] rdata;
    wire [23:0] src, dst;
    wire        breq, bdone, single, ack_n, ack_w, irq, word;
    integer     n_errors = 0, checks = 0;

    sadc_channel #(.IS_CHAN_B(1)) dut_u (.mclk_i(mclk), .nrst_i(nrst),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .adc_end_i(reqs[0]),
        .tx_empty_i(reqs[1]), .rx_full_i(reqs[2]),
        .timer_cmp_a_i(reqs[8:3]), .ext_req_i(reqs[9]), .bus_req_o(breq),
        .bus_done_i(bdone), .src_addr_o(src), .dst_addr_o(dst),
        .word_o(word), .single_o(single), .xfer_ack_strobe_n_o(ack_n),
        .xfer_ack_write_o(ack_w), .end_irq_o(irq));
    sadc_bus_model bus_u (.mclk_i(mclk), .nrst_i(nrst), .bus_req_i(breq),
        .wait_i(wt), .bus_done_o(bdone));

    initial forever #5 mclk = ~mclk;

    task stop_test;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask
    task wreg(input [3:0] a, input [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task rreg(input [3:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // One request pulse, then a bounded window that captures the access
    task xfer(input [3:0] s);
        integer i;
        @(posedge mclk);
        reqs <= 10'h001 << s;
        @(posedge mclk);
        reqs <= 10'h000;
        got = 1'b0;
        sl = 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            @(posedge mclk);
            #1;
            if (breq === 1'b1)
                sl = ack_n;
            if (breq === 1'b1 && !got) begin
                got = 1'b1;
                sa = src;
                da = dst;
                sn = ack_n;
                sw = ack_w;
            end
        end
    endtask
    task t_idle;
        rreg(4'h3);
        chk("ctrl reset", d, `SADC_RST_CTRL);
        rreg(4'h7);
        chk("unmapped", d, 32'h0);
        wreg(4'h0, 32'h123456);
        wreg(4'h1, 32'hABCD);
        wreg(4'h2, 32'h2);
        wreg(4'h3, 32'h218);
        xfer(4'h0);
        chk("src", sa, 24'h123456);
        chk("dst", da, 24'hFFABCD);
        rreg(4'h2);
        chk("count", d, 32'h1);
        xfer(4'h0);
        chk("src fixed", sa, 24'h123456);
        chk("dst fixed", da, 24'hFFABCD);
        rreg(4'h3);
        chk("enable off", d, 32'h018);
        chk("irq", irq, 1'b1);
        xfer(4'h0);
        chk("stopped", got, 1'b0);
        wreg(4'h5, 32'h1);
        wreg(4'h2, 32'h1);
        wreg(4'h3, 32'h219);
        xfer(4'h0);
        chk("src swap", sa, 24'hFFABCD);
        chk("dst swap", da, 24'h123456);
        wreg(4'h5, 32'h1);
    endtask
    task t_sources;
        integer s;
        wreg(4'h2, 32'h0);
        for (s = 0; s < 10; s = s + 1) begin
            wreg(4'h3, 32'h218 | (s << 5));
            xfer((s + 1) % 10);
            chk("other source", got, 1'b0);
            xfer(s[3:0]);
            chk("source", got, 1'b1);
        end
        rreg(4'h2);
        chk("count wrap", d, 32'hFFF6);
    endtask
    // Repeat round of n elements; n of zero stands for 256
    task t_repeat(input [23:0] m, input [7:0] n, input sz, input dn);
        integer k, nn;
        nn = (n == 0) ? 256 : n;
        wreg(4'h0, {8'h0, m});
        wreg(4'h2, {16'h0, n, n});
        wreg(4'h3, 32'h210 | (sz << 1) | (dn << 2));
        for (k = 0; k < nn; k = k + 1) begin
            xfer(4'h0);
            chk("step", sa, dn ? m - k * (sz + 1) : m + k * (sz + 1));
            if (k == 0) begin
                chk("size", word, sz);
                wreg(4'h3, 32'h010 | (sz << 1) | (dn << 2));
                xfer(4'h0);
                chk("paused", got, 1'b0);
                wreg(4'h3, 32'h210 | (sz << 1) | (dn << 2));
            end
        end
        rreg(4'h0);
        chk("restore", d, m);
        rreg(4'h2);
        chk("reload", d, {n, n});
        xfer(4'h0);
        chk("next round", sa, m);
        chk("no irq", irq, 1'b0);
        wreg(4'h3, 32'h0);
    endtask
    task t_single;
        wreg(4'h4, 32'h1);
        wreg(4'h0, 32'h40);
        wreg(4'h2, 32'h1);
        wreg(4'h3, 32'h338);
        xfer(4'h9);
        chk("strobe", sn, 1'b0);
        chk("write role", sw, 1'b1);
        chk("one cycle", da, sa);
        chk("strobe off", ack_n, 1'b1);
        chk("strobe held", sl, 1'b0);
        chk("irq", irq, 1'b1);
        wreg(4'h2, 32'h1);
        wreg(4'h3, 32'h339);
        wt <= 4'h2;
        xfer(4'h9);
        chk("read role", sw, 1'b0);
        chk("strobe held", sl, 1'b0);
        chk("mem addr", sa, 24'h40);
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        t_idle;
        t_sources;
        wt <= 4'h3;
        t_repeat(24'h000100, 8'h03, 1'b1, 1'b0);
        t_repeat(24'h000200, 8'h02, 1'b0, 1'b1);
        t_repeat(24'h001000, 8'h00, 1'b0, 1'b0);
        wt <= 4'h0;
        t_single;
        stop_test;
    end
    initial begin
        #600000;
        n_errors = n_errors + 1;
        stop_test;
    end
endmodule
